// file: fpc_pkg.sv
// package for the floating-point operand classifier front end
package fpc_pkg;
	localparam int unsigned FPC_ADDR_W = 12;
	localparam logic [11:0] FPC_CTRL_OFF = 12'h000;
	localparam logic [11:0] FPC_RF_BASE = 12'h100;
	localparam logic [11:0] FPC_RF_LAST = 12'h17c;
	localparam logic [31:0] FPC_CTRL_RESET = 32'h0004_0001;
	localparam logic [31:0] FPC_CTRL_WMASK = 32'h0007_ffff;
	localparam int unsigned FPC_RM_LSB = 0;
	localparam int unsigned FPC_FLAG_LSB = 2;
	localparam int unsigned FPC_EN_LSB = 7;
	localparam int unsigned FPC_CAUSE_LSB = 12;
	localparam int unsigned FPC_DN_BIT = 18;
	localparam logic [1:0] FPC_RM_NEAREST = 2'h0;
	localparam logic [1:0] FPC_RM_ZERO = 2'h1;
	localparam int unsigned FPC_BIAS_S = 127;
	localparam int unsigned FPC_BIAS_D = 1023;
	localparam logic [31:0] FPC_QNAN_S = 32'h7fbf_ffff;
	localparam logic [63:0] FPC_QNAN_D = 64'h7ff7_ffff_ffff_ffff;
	localparam logic [1:0] FPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] FPC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {FPC_OP_COPY, FPC_OP_ABS, FPC_OP_NEG, FPC_OP_VALUE} fpc_op_e;

	typedef struct packed {
		logic zero;
		logic denorm;
		logic normal;
		logic inf;
		logic snan;
		logic qnan;
	} fpc_class_s;

	// cause field order: error, invalid, divide by zero, overflow, underflow, inexact
	typedef struct packed {
		logic err;
		logic inv;
		logic dz;
		logic ovf;
		logic unf;
		logic inx;
	} fpc_exc_s;
endpackage

// file: fpc_classify.sv
// floating-point operand decode, classification, NaN and denormal handling with AXI4-Lite control
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpc_classify
	import fpc_pkg::*;
(
	input wire logic aclk, // core clock
	input wire logic aresetn, // synchronous reset
	input wire logic [fpc_pkg::FPC_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [fpc_pkg::FPC_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic fpu_disable_bit, // unit disable from processor_status_word
	input wire logic issue_valid, // instruction issued this cycle
	input wire fpc_pkg::fpc_op_e issue_op, // copy, abs, negate or value op
	input wire logic issue_dbl, // double precision
	input wire logic [4:0] issue_src_a, // first source register
	input wire logic [4:0] issue_src_b, // second source register
	input wire logic [4:0] issue_dst, // destination register
	input wire logic [3:0] issue_arith_exc, // divide, overflow, underflow, inexact from datapath
	output logic done_ff, // instruction completed, pulse
	output logic disable_exc_ff, // disable exception, pulse
	output logic fp_exc_ff, // enabled exception trap, pulse
	output logic dst_written_ff, // destination updated, pulse
	output logic [63:0] result_ff, // produced value
	output fpc_pkg::fpc_class_s class_a_s_ff, // operand a as single
	output fpc_pkg::fpc_class_s class_b_s_ff, // operand b as single
	output fpc_pkg::fpc_class_s class_a_d_ff, // operand a as double
	output fpc_pkg::fpc_class_s class_b_d_ff, // operand b as double
	output logic [1:0] rounding_select_ff // current rounding mode
);
	logic [31:0] ctrl_ff;
	logic [31:0] nxt_ctrl;
	logic [31:0] rf_mem [32];
	logic [FPC_ADDR_W-1:0] wr_addr;
	logic wr_fire;
	logic wr_ok;
	logic bus_wr_ctrl;
	logic [31:0] wr_mask;
	logic [31:0] opa_s, opb_s;
	logic [63:0] opa_d, opb_d;
	fpc_class_s ca_s, cb_s, ca_d, cb_d, ca, cb;
	logic is_value, any_snan, any_qnan, en_inv, dn_mode, rm_bad, trap;
	fpc_exc_s cause;
	logic [63:0] opa, val_out, ins_result;

	function automatic fpc_class_s classify(input logic e_ones, input logic e_zero, input logic f_nz,
		input logic f_msb);
		fpc_class_s c;
		c.zero = e_zero & ~f_nz;
		c.denorm = e_zero & f_nz;
		c.normal = ~e_zero & ~e_ones;
		c.inf = e_ones & ~f_nz;
		c.snan = e_ones & f_nz & f_msb;
		c.qnan = e_ones & f_nz & ~f_msb;
		return c;
	endfunction

	// operands: double register pair is even index high, odd index low
	assign opa_s = rf_mem[issue_src_a];
	assign opb_s = rf_mem[issue_src_b];
	assign opa_d = {rf_mem[{issue_src_a[4:1], 1'b0}], rf_mem[{issue_src_a[4:1], 1'b1}]};
	assign opb_d = {rf_mem[{issue_src_b[4:1], 1'b0}], rf_mem[{issue_src_b[4:1], 1'b1}]};
	assign ca_s = classify(&opa_s[30:23], ~|opa_s[30:23], |opa_s[22:0], opa_s[22]);
	assign cb_s = classify(&opb_s[30:23], ~|opb_s[30:23], |opb_s[22:0], opb_s[22]);
	assign ca_d = classify(&opa_d[62:52], ~|opa_d[62:52], |opa_d[51:0], opa_d[51]);
	assign cb_d = classify(&opb_d[62:52], ~|opb_d[62:52], |opb_d[51:0], opb_d[51]);
	assign ca = issue_dbl ? ca_d : ca_s;
	assign cb = issue_dbl ? cb_d : cb_s;
	assign opa = issue_dbl ? opa_d : {32'h0000_0000, opa_s};

	assign is_value = issue_op == FPC_OP_VALUE;
	assign any_snan = ca.snan | cb.snan;
	assign any_qnan = ca.qnan | cb.qnan;
	assign en_inv = ctrl_ff[FPC_EN_LSB+4];
	assign dn_mode = ctrl_ff[FPC_DN_BIT];
	assign rm_bad = ctrl_ff[FPC_RM_LSB+1];
	assign cause = '{err: rm_bad, inv: any_snan, dz: issue_arith_exc[3], ovf: issue_arith_exc[2],
		unf: issue_arith_exc[1], inx: issue_arith_exc[0]};
	assign trap = cause.err | (|(cause[4:0] & ctrl_ff[FPC_EN_LSB+:5]));

	// value result: NaN handling first, then denormal flush of the passed operand
	always_comb
	begin
		if (any_snan | any_qnan)
			val_out = issue_dbl ? FPC_QNAN_D : {32'h0000_0000, FPC_QNAN_S};
		else if (dn_mode & ca.denorm)
			val_out = issue_dbl ? {opa[63], 63'h0} : {32'h0000_0000, opa[31], 31'h0};
		else
			val_out = opa;
	end

	// AXI4-Lite write: address and data taken together, response next cycle
	assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
	assign wr_addr = s_axi_awaddr;
	assign wr_ok = (wr_addr == FPC_CTRL_OFF) | ((wr_addr >= FPC_RF_BASE) & (wr_addr <= FPC_RF_LAST)
		& (wr_addr[1:0] == 2'h0));
	assign bus_wr_ctrl = wr_fire & (wr_addr == FPC_CTRL_OFF);
	assign wr_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= FPC_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= wr_fire;
			s_axi_wready <= wr_fire;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? FPC_RESP_OKAY : FPC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= FPC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid)
			begin
				s_axi_rvalid <= 1'b1;
				if (s_axi_araddr == FPC_CTRL_OFF)
				begin
					s_axi_rdata <= ctrl_ff;
					s_axi_rresp <= FPC_RESP_OKAY;
				end
				else if ((s_axi_araddr >= FPC_RF_BASE) & (s_axi_araddr <= FPC_RF_LAST) & (s_axi_araddr[1:0] == 2'h0))
				begin
					s_axi_rdata <= rf_mem[s_axi_araddr[6:2]];
					s_axi_rresp <= FPC_RESP_OKAY;
				end
				else
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= FPC_RESP_SLVERR;
				end
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// control/status: software write merged first, hardware cause and flag set on top
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (bus_wr_ctrl)
			nxt_ctrl = ((ctrl_ff & ~wr_mask) | (s_axi_wdata & wr_mask)) & FPC_CTRL_WMASK;
		if (issue_valid & ~fpu_disable_bit & is_value)
		begin
			nxt_ctrl[FPC_CAUSE_LSB+:6] = cause;
			nxt_ctrl[FPC_FLAG_LSB+:5] = nxt_ctrl[FPC_FLAG_LSB+:5] | cause[4:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_ff <= FPC_CTRL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	always_ff @(posedge aclk)
	begin
		rounding_select_ff <= !aresetn ? FPC_CTRL_RESET[1:0] : nxt_ctrl[1:0];
	end

	// register file: bus writes, then instruction writes take priority on the same word
	always_ff @(posedge aclk)
	begin
		if (wr_fire & wr_ok & (wr_addr != FPC_CTRL_OFF))
			rf_mem[wr_addr[6:2]] <= (rf_mem[wr_addr[6:2]] & ~wr_mask) | (s_axi_wdata & wr_mask);
		if (issue_valid & ~fpu_disable_bit & ~(is_value & trap))
		begin
			if (issue_dbl)
			begin
				rf_mem[{issue_dst[4:1], 1'b0}] <= ins_result[63:32];
				rf_mem[{issue_dst[4:1], 1'b1}] <= ins_result[31:0];
			end
			else
				rf_mem[issue_dst] <= ins_result[31:0];
		end
	end

	// copy, absolute value and negate skip NaN handling and flushing
	function automatic logic [63:0] nxt_result(input logic dbl);
		logic [63:0] r;
		r = val_out;
		case (issue_op)
			FPC_OP_COPY: r = opa;
			FPC_OP_ABS: r = dbl ? {1'b0, opa[62:0]} : {32'h0000_0000, 1'b0, opa[30:0]};
			FPC_OP_NEG: r = dbl ? {~opa[63], opa[62:0]} : {32'h0000_0000, ~opa[31], opa[30:0]};
			default: r = val_out;
		endcase
		return r;
	endfunction

	assign ins_result = nxt_result(issue_dbl);

	// instruction outcome
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_ff <= 1'b0;
			disable_exc_ff <= 1'b0;
			fp_exc_ff <= 1'b0;
			dst_written_ff <= 1'b0;
			result_ff <= 64'h0;
		end
		else
		begin
			done_ff <= issue_valid & ~fpu_disable_bit;
			disable_exc_ff <= issue_valid & fpu_disable_bit;
			fp_exc_ff <= issue_valid & ~fpu_disable_bit & is_value & trap;
			dst_written_ff <= issue_valid & ~fpu_disable_bit & ~(is_value & trap);
			if (issue_valid & ~fpu_disable_bit)
				result_ff <= ins_result;
		end
	end

	// classes presented with each decoded instruction
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			class_a_s_ff <= '0;
			class_b_s_ff <= '0;
			class_a_d_ff <= '0;
			class_b_d_ff <= '0;
		end
		else if (issue_valid)
		begin
			class_a_s_ff <= ca_s;
			class_b_s_ff <= cb_s;
			class_a_d_ff <= ca_d;
			class_b_d_ff <= cb_d;
		end
	end

	// true exponent helpers, bias view of the stored code
	logic signed [11:0] true_exp_a_s;
	assign true_exp_a_s = $signed({4'h0, opa_s[30:23]}) - 12'sd127;

	default clocking cb_clk @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_disable_refuse: assert property (issue_valid && fpu_disable_bit |=> disable_exc_ff && !done_ff && !dst_written_ff)
		else $error("disabled unit executed an instruction");
	a_snan_trap_hold: assert property (issue_valid && !fpu_disable_bit && is_value && any_snan && en_inv
		|=> fp_exc_ff && !dst_written_ff)
		else $error("signalling NaN with invalid enable did not trap");
	a_snan_quiet_out: assert property (issue_valid && !fpu_disable_bit && is_value && !issue_dbl && any_snan && !trap
		|=> result_ff[31:0] == FPC_QNAN_S && dst_written_ff)
		else $error("signalling NaN did not give quiet NaN");
	a_qnan_no_exc: assert property (issue_valid && !fpu_disable_bit && is_value && any_qnan && !any_snan
		&& issue_arith_exc == 4'h0 && !rm_bad |=> !fp_exc_ff && !ctrl_ff[FPC_CAUSE_LSB+4])
		else $error("quiet NaN raised an exception");
	a_dbl_qnan_pat: assert property (issue_valid && !fpu_disable_bit && is_value && issue_dbl && any_qnan && !trap
		|=> result_ff == FPC_QNAN_D)
		else $error("double quiet NaN pattern wrong");
	a_denorm_flush: assert property (issue_valid && !fpu_disable_bit && is_value && !issue_dbl && dn_mode
		&& ca_s.denorm && !any_snan && !any_qnan |=> result_ff[30:0] == 31'h0)
		else $error("denormal not flushed");
	a_denorm_keep: assert property (issue_valid && !fpu_disable_bit && is_value && !issue_dbl && !dn_mode
		&& ca_s.denorm && !any_snan && !any_qnan |=> result_ff[31:0] == $past(opa_s))
		else $error("denormal altered without flush mode");
	a_class_onehot: assert property (issue_valid |=> $onehot(class_a_s_ff) && $onehot(class_b_d_ff))
		else $error("operand class not one-hot");
	a_flag_sticky: assert property (!bus_wr_ctrl |=> ($past(ctrl_ff[FPC_FLAG_LSB+:5]) & ~ctrl_ff[FPC_FLAG_LSB+:5]) == 5'h0)
		else $error("sticky flag dropped without software write");
	a_rm_reserved: assert property (issue_valid && !fpu_disable_bit && is_value && rm_bad
		|=> ctrl_ff[FPC_CAUSE_LSB+5] && fp_exc_ff)
		else $error("reserved rounding code not reported");
	a_bias_range: assert property (issue_valid && !issue_dbl && ca_s.normal
		|-> true_exp_a_s >= -12'sd126 && true_exp_a_s <= 12'sd127)
		else $error("normal single exponent outside biased range");

	c_disabled: cover property (issue_valid && fpu_disable_bit);
	c_snan_trap: cover property (issue_valid && is_value && any_snan && en_inv);
	c_flush: cover property (issue_valid && is_value && dn_mode && ca.denorm);
	c_double_op: cover property (issue_valid && issue_dbl && is_value ##1 dst_written_ff);
endmodule // fpc_classify
`default_nettype wire

// file: fpc_core_model.sv
// stand-in for the core pipeline that issues instructions to the classifier
`timescale 1ns/1ps
`default_nettype none
module fpc_core_model
	import fpc_pkg::*;
(
	input wire logic aclk, // core clock
	input wire logic go, // issue request for the next edge
	input wire fpc_pkg::fpc_op_e op, // requested operation
	input wire logic [19:0] fld, // {dbl, src_a, src_b, dst, arith_exc}
	output logic issue_valid_ff = 1'b0, // issue strobe
	output fpc_pkg::fpc_op_e op_ff = FPC_OP_COPY, // issued operation
	output logic [19:0] fld_ff = 20'h0 // issued fields
);
	// fields wander between issues so stale values never look valid
	always @(posedge aclk)
	begin
		issue_valid_ff <= go;
		op_ff <= go ? op : fpc_op_e'(~op_ff);
		fld_ff <= go ? fld : ~fld_ff;
	end
endmodule // fpc_core_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the operand classifier
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fpc_pkg::*;
	logic aclk = 0, aresetn = 0, go = 0, dis = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, iv, done_ff, dexc_ff, fexc_ff, wr_ff;
	logic [1:0] bresp, rresp, rs, r;
	logic [63:0] res, va, vb;
	logic [19:0] fld = 20'h0, ifld;
	fpc_op_e op = FPC_OP_VALUE, iop, o;
	fpc_class_s cas, cbs, cad, cbd;
	logic dbl, fl, rm;
	int error_cnt = 0, tests_run = 0, cyc = 0, i;

	fpc_core_model core (.aclk(aclk), .go(go), .op(op), .fld(fld), .issue_valid_ff(iv), .op_ff(iop), .fld_ff(ifld));
	fpc_classify DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fpu_disable_bit(dis),
		.issue_valid(iv), .issue_op(iop), .issue_dbl(ifld[19]), .issue_src_a(ifld[18:14]),
		.issue_src_b(ifld[13:9]), .issue_dst(ifld[8:4]), .issue_arith_exc(ifld[3:0]), .done_ff(done_ff),
		.disable_exc_ff(dexc_ff), .fp_exc_ff(fexc_ff), .dst_written_ff(wr_ff), .result_ff(res),
		.class_a_s_ff(cas), .class_b_s_ff(cbs), .class_a_d_ff(cad), .class_b_d_ff(cbd),
		.rounding_select_ff(rs));

	initial forever #12.5 aclk = ~aclk;

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] dd);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dd;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		r = rresp;
		d = rdata;
	endtask

	// results are looked at in the cycle the done or refusal pulse stands
	task automatic ex(input fpc_op_e oo, input logic [19:0] f);
		int n;
		n = 0;
		@(posedge aclk);
		op <= oo;
		fld <= f;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (done_ff !== 1'b1 && dexc_ff !== 1'b1 && n < 8);
		if (done_ff !== 1'b1 && dexc_ff !== 1'b1)
		begin
			$display("[ERR] issue answer expected 1 seen 0");
			error_cnt++;
		end
	endtask

	// {zero, denorm, normal, inf, snan, qnan}
	function automatic logic [5:0] cls(input logic [63:0] v, input logic db);
		logic mx, mn, fz, fm;
		mx = db ? &v[62:52] : &v[30:23];
		mn = db ? ~|v[62:52] : ~|v[30:23];
		fz = db ? ~|v[51:0] : ~|v[22:0];
		fm = db ? v[51] : v[22];
		return {mn & fz, mn & !fz, !mx & !mn, mx & fz, mx & !fz & fm, mx & !fz & !fm};
	endfunction

	function automatic logic [63:0] eres(input logic [63:0] a, b, input logic db, f, input fpc_op_e oo);
		logic [5:0] ca, cb;
		logic [63:0] s;
		ca = cls(a, db);
		cb = cls(b, db);
		s = db ? 64'h8000_0000_0000_0000 : 64'h8000_0000;
		if (oo == FPC_OP_COPY) return a;
		if (oo == FPC_OP_ABS) return a & ~s;
		if (oo == FPC_OP_NEG) return a ^ s;
		if (|{ca[1:0], cb[1:0]}) return db ? FPC_QNAN_D : {32'h0, FPC_QNAN_S};
		if (f && ca[4]) return a & s;
		return a;
	endfunction

	// extreme exponents and zero fractions are drawn often
	function automatic logic [63:0] gen(input logic db);
		logic [31:0] hi, lo;
		logic [2:0] k;
		hi = $urandom;
		lo = $urandom;
		k = 3'($urandom);
		if (!k[1]) hi[30:20] = {11{k[0]}};
		if (k[2] && db) {hi[19:0], lo} = 52'h0;
		if (k[2] && !db) hi[22:0] = 23'h0;
		return db ? {hi, lo} : {32'h0, hi};
	endfunction

	initial
	begin
		void'($urandom(30262));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(FPC_CTRL_OFF);
		chk("ctrl reset", FPC_CTRL_RESET, d);
		chk("rounding reset", FPC_RM_ZERO, rs);
		rd(12'h200);
		chk("unmapped rresp", FPC_RESP_SLVERR, r);
		wr(12'h004, 32'h1);
		chk("unmapped bresp", FPC_RESP_SLVERR, r);
		wr(FPC_RF_BASE, 32'h7fc0_0000);
		wr(FPC_RF_BASE + 12'h4, 32'h3f80_0000);
		wr(FPC_RF_BASE + 12'h24, 32'h1234_5678);
		ex(FPC_OP_VALUE, {1'b0, 5'd0, 5'd1, 5'd8, 4'h0});
		chk("snan result", {32'h0, FPC_QNAN_S}, res);
		chk("snan class", 6'b000010, cas);
		rd(FPC_RF_BASE + 12'h20);
		chk("dst word", FPC_QNAN_S, d);
		rd(FPC_CTRL_OFF);
		chk("cause and flag", 32'h0005_0041, d);
		wr(FPC_CTRL_OFF, 32'h0004_0801);
		ex(FPC_OP_VALUE, {1'b0, 5'd0, 5'd1, 5'd9, 4'h0});
		chk("invalid trap", 1'b1, fexc_ff);
		chk("trap write", 1'b0, wr_ff);
		rd(FPC_RF_BASE + 12'h24);
		chk("dst kept", 32'h1234_5678, d);
		wr(FPC_RF_BASE, 32'hffbf_ffff);
		ex(FPC_OP_VALUE, {1'b0, 5'd1, 5'd0, 5'd9, 4'h0});
		chk("qnan trap", 1'b0, fexc_ff);
		chk("qnan result", {32'h0, FPC_QNAN_S}, res);
		rd(FPC_CTRL_OFF);
		chk("cause cleared", 6'h0, d[17:12]);
		wstrb <= 4'h1;
		wr(FPC_RF_BASE + 12'h24, 32'h0000_00aa);
		wstrb <= 4'hf;
		rd(FPC_RF_BASE + 12'h24);
		chk("byte lane", 32'h7fbf_ffaa, d);
		dis <= 1'b1;
		ex(FPC_OP_VALUE, {1'b0, 5'd1, 5'd1, 5'd9, 4'h0});
		chk("disable exc", 1'b1, dexc_ff);
		chk("disable done", 1'b0, done_ff);
		dis <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			wr(FPC_CTRL_OFF, 32'h0004_0000 | i);
			ex(FPC_OP_VALUE, {1'b0, 5'd1, 5'd1, 5'd10, 4'h0});
			chk("rounding", i[1:0], rs);
			chk("reserved rounding trap", i > 1, fexc_ff);
		end
		for (i = 0; i < 60; i++)
		begin
			dbl = 1'($urandom);
			fl = 1'($urandom);
			rm = 1'($urandom);
			o = fpc_op_e'($urandom % 4);
			va = gen(dbl);
			vb = gen(dbl);
			wr(12'h108, dbl ? va[63:32] : va[31:0]);
			wr(12'h10c, va[31:0]);
			wr(12'h110, dbl ? vb[63:32] : vb[31:0]);
			wr(12'h114, vb[31:0]);
			wr(FPC_CTRL_OFF, {13'h0, fl, 17'h0, rm});
			ex(o, {dbl, 5'd2, 5'd4, 5'd6, 4'($urandom)});
			chk("result", eres(va, vb, dbl, fl, o), res);
			chk("class a", cls(va, dbl), dbl ? cad : cas);
			chk("class b", cls(vb, dbl), dbl ? cbd : cbs);
		end
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
